// [fault_behaviour_pkg.sv]
package fault_behaviour_pkg;
  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] ADDR_ERR_TALLY = 12'h030d;
  localparam logic [11:0] ADDR_CH1_BEH   = 12'h0f00;
  localparam logic [11:0] ADDR_CH2_BEH   = 12'h0f01;
  localparam logic [7:0]  RST_ERR_TALLY  = 8'h00;
  localparam logic [7:0]  RST_BEH        = 8'h00;
  // ---------------------------------------------------------------------------
  // behaviour byte fields
  // ---------------------------------------------------------------------------
  localparam int BEH_EN_BIT  = 0;
  localparam int BEH_SEQ_LSB = 1;
  localparam int BEH_TMO_LSB = 4;
  localparam int CODE_W      = 3;
  // ---------------------------------------------------------------------------
  // substitute output codes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CODE_ZERO  = 3'b000,
    CODE_ONE   = 3'b001,
    CODE_HOLD  = 3'b010,
    CODE_REP   = 3'b011,
    CODE_ALT   = 3'b100,
    CODE_OFF   = 3'b101
  } fault_code_t;
  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam longint CLK_HZ        = 40_000_000;
  localparam longint TIMEOUT_MS    = 100;
  localparam longint TIMEOUT_CYC   = (TIMEOUT_MS * CLK_HZ) / 1000;
  localparam logic [7:0] SEQ_STEP  = 8'h01;
endpackage : fault_behaviour_pkg

// [output_fault_behaviour_control.sv]
`timescale 1ns/1ps
`default_nettype none
module output_fault_behaviour_control
  import fault_behaviour_pkg::*;
#(
  parameter int          NCH         = 2,
  parameter int          SAMPLES     = 8,
  parameter longint      TIMEOUT_CNT = TIMEOUT_CYC
) (
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  // cyclic data from the bus side
  input  wire logic               cycle_valid_i,
  input  wire logic               sequence_check_enable_i,
  input  wire logic [7:0]         sequence_tally_value_i,
  input  wire logic [NCH*SAMPLES-1:0] cycle_data_i,
  // output sample strobe
  input  wire logic               sample_tick_i,
  // acyclic register port
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  input  wire logic [11:0]        reg_addr_i,
  input  wire logic [15:0]        reg_wdata_i,
  input  wire logic [1:0]         reg_be_i,
  output logic      [15:0]        reg_rdata_o,
  // channel outputs
  output logic      [NCH-1:0]     chan_out_o,
  output logic      [NCH-1:0]     chan_oe_o,
  output logic                    seq_error_o,
  output logic                    timeout_o
);
  import fault_behaviour_pkg::*;

  localparam int SW = (SAMPLES > 1) ? $clog2(SAMPLES) : 1;
  localparam int TW = $clog2(TIMEOUT_CNT + 1);

  function automatic logic [CODE_W-1:0] field(input logic [7:0] b, input int lsb);
    field = b[lsb +: CODE_W];
  endfunction : field

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic [7:0]            tally_q, tally_d;
  logic [7:0]            beh_q [NCH], beh_d [NCH];
  logic [7:0]            last_seq_q, last_seq_d;
  logic                  seq_seen_q, seq_seen_d;
  logic                  seq_err_q, seq_err_d;
  logic                  got_cyc_q, got_cyc_d;
  logic [TW-1:0]         tmo_q, tmo_d;
  logic                  expired_q, expired_d;
  logic [NCH*SAMPLES-1:0] buf_q, buf_d;
  logic [SW-1:0]         idx_q, idx_d;
  logic [NCH-1:0]        last_bit_q, last_bit_d;
  logic [NCH-1:0]        alt_q, alt_d;
  logic [NCH-1:0]        out_q, out_d, oe_q, oe_d;
  logic [15:0]           rdata_q, rdata_d;
  logic                  step_ok;

  // ---------------------------------------------------------------------------
  // sequence check, tally, timeout, register port
  // ---------------------------------------------------------------------------
  always_comb begin
    tally_d    = tally_q;
    beh_d      = beh_q;
    last_seq_d = last_seq_q;
    seq_seen_d = seq_seen_q;
    seq_err_d  = seq_err_q;
    got_cyc_d  = got_cyc_q;
    tmo_d      = tmo_q;
    expired_d  = expired_q;
    buf_d      = buf_q;
    rdata_d    = rdata_q;
    step_ok    = (sequence_tally_value_i == last_seq_q + SEQ_STEP);
    // register writes; tally write loads the low data byte
    if (reg_wr_i) begin
      if (reg_addr_i == ADDR_ERR_TALLY && reg_be_i[0]) tally_d = reg_wdata_i[7:0];
      if (reg_addr_i == ADDR_CH1_BEH) begin
        if (reg_be_i[0]) beh_d[0] = reg_wdata_i[7:0];
        if (reg_be_i[1]) beh_d[1] = reg_wdata_i[15:8];
      end
    end
    if (cycle_valid_i) begin
      buf_d     = cycle_data_i;
      tmo_d     = TW'(TIMEOUT_CNT);
      expired_d = 1'b0;
      last_seq_d = sequence_tally_value_i;
      seq_seen_d = sequence_check_enable_i;
      seq_err_d  = 1'b0;
      if (sequence_check_enable_i && seq_seen_q && !step_ok) begin
        tally_d = tally_q + 8'h01; // set wins over clear
      end
    end else begin
      if (tmo_q != '0) tmo_d = tmo_q - TW'(1);
      else expired_d = 1'b1;
    end
    // a block that ends with no cycle since the last block end is a missed sync event
    if (cycle_valid_i) got_cyc_d = 1'b1;
    if (sample_tick_i && idx_q == SW'(SAMPLES - 1)) begin
      if (!got_cyc_q && !cycle_valid_i && seq_seen_q) seq_err_d = 1'b1;
      got_cyc_d = cycle_valid_i;
    end
    rdata_d = 16'h0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_ERR_TALLY: rdata_d = {8'h00, tally_q};
        ADDR_CH1_BEH:   rdata_d = {beh_q[1], beh_q[0]};
        ADDR_CH2_BEH:   rdata_d = {8'h00, beh_q[1]};
        default:        rdata_d = 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // output selection
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [CODE_W-1:0] code;
    logic              sample;
    code       = '0;
    sample     = 1'b0;
    out_d      = out_q;
    oe_d       = oe_q;
    last_bit_d = last_bit_q;
    alt_d      = alt_q;
    idx_d      = idx_q;
    if (sample_tick_i) begin
      idx_d = (idx_q == SW'(SAMPLES - 1)) ? '0 : idx_q + SW'(1);
      for (int c = 0; c < NCH; c++) begin
        sample = buf_q[c*SAMPLES + int'(idx_q)];
        oe_d[c] = 1'b1;
        if (expired_q) begin
          code = beh_q[c][BEH_EN_BIT] ? field(beh_q[c], BEH_TMO_LSB) : CODE_ZERO;
        end else if (seq_err_q) begin
          code = beh_q[c][BEH_EN_BIT] ? field(beh_q[c], BEH_SEQ_LSB) : CODE_ZERO;
        end else begin
          code = CODE_REP; // normal path and unchecked repeat
        end
        unique case (code)
          CODE_ZERO: out_d[c] = 1'b0;
          CODE_ONE:  out_d[c] = 1'b1;
          CODE_HOLD: out_d[c] = last_bit_q[c];
          CODE_REP:  out_d[c] = sample;
          CODE_ALT:  out_d[c] = alt_q[c];
          CODE_OFF: begin
            out_d[c] = 1'b0;
            oe_d[c]  = 1'b0;
          end
          default:   out_d[c] = 1'b0;
        endcase
        alt_d[c] = (code == CODE_ALT) ? ~alt_q[c] : 1'b0;
        if (!expired_q && !seq_err_q && idx_q == SW'(SAMPLES - 1)) last_bit_d[c] = sample;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tally_q    <= RST_ERR_TALLY;
      for (int c = 0; c < NCH; c++) beh_q[c] <= RST_BEH;
      last_seq_q <= 8'h00;
      seq_seen_q <= 1'b0;
      seq_err_q  <= 1'b0;
      got_cyc_q  <= 1'b0;
      tmo_q      <= TW'(TIMEOUT_CNT);
      expired_q  <= 1'b0;
      buf_q      <= '0;
      idx_q      <= '0;
      last_bit_q <= '0;
      alt_q      <= '0;
      out_q      <= '0;
      oe_q       <= '0;
      rdata_q    <= 16'h0000;
    end else begin
      tally_q    <= tally_d;
      beh_q      <= beh_d;
      last_seq_q <= last_seq_d;
      seq_seen_q <= seq_seen_d;
      seq_err_q  <= seq_err_d;
      got_cyc_q  <= got_cyc_d;
      tmo_q      <= tmo_d;
      expired_q  <= expired_d;
      buf_q      <= buf_d;
      idx_q      <= idx_d;
      last_bit_q <= last_bit_d;
      alt_q      <= alt_d;
      out_q      <= out_d;
      oe_q       <= oe_d;
      rdata_q    <= rdata_d;
    end
  end

  assign chan_out_o  = out_q;
  assign chan_oe_o   = oe_q;
  assign reg_rdata_o = rdata_q;
  assign seq_error_o = seq_err_q;
  assign timeout_o   = expired_q;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // ---------------------------------------------------------------------------
  // sequence check and tally
  // ---------------------------------------------------------------------------
  chk_tally_bad_step: assert property (
    cycle_valid_i && sequence_check_enable_i && seq_seen_q && !step_ok && !reg_wr_i
    |=> tally_q == $past(tally_q) + 8'h01) else $error("tally did not count bad step");
  chk_tally_wrap_ok: assert property (
    cycle_valid_i && last_seq_q == 8'hff && sequence_tally_value_i == 8'h00 && !reg_wr_i
    |=> tally_q == $past(tally_q)) else $error("wrap counted as error");
  chk_tally_good_step: assert property (
    cycle_valid_i && step_ok && !reg_wr_i |=> $stable(tally_q)) else $error("good step counted");
  chk_tally_clear: assert property (
    reg_wr_i && reg_addr_i == ADDR_ERR_TALLY && reg_be_i[0] && !cycle_valid_i
    |=> tally_q == $past(reg_wdata_i[7:0])) else $error("tally write lost");
  chk_seq_err_set: assert property (
    sample_tick_i && idx_q == SW'(SAMPLES - 1) && !got_cyc_q && !cycle_valid_i && seq_seen_q
    |=> seq_err_q) else $error("missed cycle not flagged");
  chk_seq_err_clear: assert property (
    cycle_valid_i |=> !seq_err_q) else $error("sequence error not cleared");

  // ---------------------------------------------------------------------------
  // timeout monitor
  // ---------------------------------------------------------------------------
  chk_timer_restart: assert property (
    cycle_valid_i |=> tmo_q == TW'(TIMEOUT_CNT) && !expired_q) else $error("timer not restarted");
  chk_timer_expire: assert property (
    !cycle_valid_i && tmo_q == '0 |=> expired_q) else $error("timer did not expire");
  chk_timer_count: assert property (
    !cycle_valid_i && tmo_q != '0 |=> tmo_q == $past(tmo_q) - TW'(1)) else $error("timer did not count");

  // ---------------------------------------------------------------------------
  // substitute outputs
  // ---------------------------------------------------------------------------
  chk_normal_repeat: assert property (
    sample_tick_i && !seq_err_q && !expired_q |=> chan_out_o[0] == $past(buf_q[idx_q]))
    else $error("buffer data not output");
  chk_timeout_low: assert property (
    sample_tick_i && expired_q && !beh_q[0][BEH_EN_BIT] |=> !chan_out_o[0]) else $error("timeout not low");
  chk_seq_err_low: assert property (
    sample_tick_i && seq_err_q && !expired_q && !beh_q[0][BEH_EN_BIT] |=> !chan_out_o[0])
    else $error("sequence error output not low");
  chk_alt_toggle: assert property (
    sample_tick_i && seq_err_q && !expired_q && beh_q[0][BEH_EN_BIT] && field(beh_q[0], BEH_SEQ_LSB) == CODE_ALT
    ##2 sample_tick_i && seq_err_q && !expired_q && beh_q[0][BEH_EN_BIT]
    && field(beh_q[0], BEH_SEQ_LSB) == CODE_ALT
    |=> chan_out_o[0] != $past(chan_out_o[0], 2)) else $error("alternate did not toggle");
  chk_one_code: assert property (
    sample_tick_i && seq_err_q && !expired_q && beh_q[0][BEH_EN_BIT] && field(beh_q[0], BEH_SEQ_LSB) == CODE_ONE
    |=> chan_out_o[0]) else $error("one code not high");
  chk_off_code: assert property (
    sample_tick_i && expired_q && beh_q[1][BEH_EN_BIT] && field(beh_q[1], BEH_TMO_LSB) == CODE_OFF
    |=> !chan_oe_o[1]) else $error("off code still driving");
  chk_hold_code: assert property (
    sample_tick_i && expired_q && beh_q[0][BEH_EN_BIT] && field(beh_q[0], BEH_TMO_LSB) == CODE_HOLD
    |=> chan_out_o[0] == $past(last_bit_q[0])) else $error("hold code lost last bit");
  chk_rep_code: assert property (
    sample_tick_i && expired_q && beh_q[1][BEH_EN_BIT] && field(beh_q[1], BEH_TMO_LSB) == CODE_REP
    |=> chan_out_o[1] == $past(buf_q[SAMPLES + int'(idx_q)])) else $error("repeat code wrong data");

  // ---------------------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------------------
  chk_beh_persist: assert property (
    !(reg_wr_i && reg_addr_i == ADDR_CH1_BEH) |=> beh_q[0] == $past(beh_q[0])) else $error("behaviour lost");
  chk_word_write: assert property (
    reg_wr_i && reg_addr_i == ADDR_CH1_BEH && reg_be_i == 2'b11
    |=> beh_q[1] == $past(reg_wdata_i[15:8]) && beh_q[0] == $past(reg_wdata_i[7:0]))
    else $error("word write lost");
  chk_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 16'h0000) else $error("read data not idle");
  chk_rdata_tally: assert property (
    reg_rd_i && reg_addr_i == ADDR_ERR_TALLY |=> reg_rdata_o == {8'h00, $past(tally_q)})
    else $error("tally read wrong");

  // ---------------------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------------------
  cov_bad_step: cover property (cycle_valid_i && seq_seen_q && sequence_check_enable_i && !step_ok);
  cov_expire:   cover property (!expired_q ##1 expired_q);
  cov_off_mode: cover property (expired_q && !chan_oe_o[1]);
  cov_alt_mode: cover property (sample_tick_i && seq_err_q && field(beh_q[0], BEH_SEQ_LSB) == CODE_ALT);
  cov_wrap:     cover property (cycle_valid_i && last_seq_q == 8'hff && sequence_tally_value_i == 8'h00);
endmodule : output_fault_behaviour_control
`default_nettype wire

// [ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ctl_model #(
  parameter int GAP = 8
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        run_i,
  input  wire logic        jump_i,
  input  wire logic [15:0] data_i,
  output logic             valid_o,
  output logic             en_o,
  output logic [7:0]       seq_o,
  output logic [15:0]      data_o
);
  int         cnt;
  logic [7:0] seq;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt = 0;
      seq = 8'hfa;
      valid_o <= 1'b0;
      en_o <= 1'b0;
      seq_o <= 8'h00;
      data_o <= 16'h0000;
    end else begin
      #1;
      cnt = (cnt + 1) % GAP;
      en_o <= run_i;
      valid_o <= run_i && cnt == 0;
      if (run_i && cnt == 0) begin
        seq = seq + (jump_i ? 8'h02 : 8'h01);
        seq_o <= seq;
        data_o <= data_i;
      end else begin
        seq_o <= ~seq;
        data_o <= ~data_o;
      end
    end
  end
endmodule : ctl_model
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fault_behaviour_pkg::*;
  logic        clk_i = 0, nrst_i = 0, run = 0, jump = 0, tick = 0;
  logic        reg_wr = 0, reg_rd = 0, valid, en, seq_err, tmo;
  logic [11:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, cdata, rnd = 16'h0000;
  logic [1:0]  reg_be = 0, chan_out, chan_oe;
  logic [7:0]  seq;
  logic [31:0] st = 45;
  logic [15:0] last_data = 16'h0000;
  logic        a0 = 0;
  int          ones = 0;
  always @(posedge clk_i) if (valid) last_data <= cdata;
  int          n_mismatch = 0, compares = 0, cyc = 0;
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] beh(logic [2:0] s, logic [2:0] t);
    return {1'b0, t, s, 1'b1};
  endfunction : beh
  task automatic end_of_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic step(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic rd(logic [11:0] a, logic [15:0] exp);
    reg_addr = a;
    reg_rd = 1;
    step(1);
    reg_rd = 0;
    chk("rdata", exp, reg_rdata);
    step(1);
  endtask : rd
  task automatic wr(logic [11:0] a, logic [15:0] d, logic [1:0] be);
    reg_addr = a;
    reg_wdata = d;
    reg_be = be;
    reg_wr = 1;
    step(1);
    reg_wr = 0;
    step(1);
  endtask : wr
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    #1;
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    tick <= ~tick;
    rnd <= st[15:0];
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  ctl_model #(.GAP(8)) i_ctl (.clk_i(clk_i), .nrst_i(nrst_i), .run_i(run), .jump_i(jump),
    .data_i(rnd), .valid_o(valid), .en_o(en), .seq_o(seq), .data_o(cdata));
  output_fault_behaviour_control #(.NCH(2), .SAMPLES(8), .TIMEOUT_CNT(80)) i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .cycle_valid_i(valid), .sequence_check_enable_i(en),
    .sequence_tally_value_i(seq), .cycle_data_i(cdata), .sample_tick_i(tick),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_be_i(reg_be), .reg_rdata_o(reg_rdata), .chan_out_o(chan_out), .chan_oe_o(chan_oe),
    .seq_error_o(seq_err), .timeout_o(tmo));
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    step(16);
    nrst_i = 1;
    step(1);
    rd(ADDR_ERR_TALLY, 16'h0000);
    rd(ADDR_CH1_BEH, 16'h0000);
    rd(12'h0123, 16'h0000);
    run = 1;
    step(100);
    rd(ADDR_ERR_TALLY, 16'h0000);
    @(posedge clk_i iff valid);
    #2 jump = 1;
    @(posedge clk_i iff valid);
    #2 jump = 0;
    step(60);
    rd(ADDR_ERR_TALLY, 16'h0001);
    wr(ADDR_ERR_TALLY, 16'h0000, 2'b01);
    rd(ADDR_ERR_TALLY, 16'h0000);
    run = 0;
    step(40);
    chk("seq_err", 16'h0001, {15'h0000, seq_err});
    chk("tmo", 16'h0000, {15'h0000, tmo});
    chk("out", 16'h0000, {14'h0000, chan_out});
    step(60);
    chk("tmo", 16'h0001, {15'h0000, tmo});
    chk("out", 16'h0000, {14'h0000, chan_out});
    chk("oe", 16'h0003, {14'h0000, chan_oe});
    wr(ADDR_CH1_BEH, {beh(CODE_ZERO, CODE_OFF), beh(CODE_ONE, CODE_ONE)}, 2'b11);
    rd(ADDR_CH1_BEH, {beh(CODE_ZERO, CODE_OFF), beh(CODE_ONE, CODE_ONE)});
    rd(ADDR_CH2_BEH, {8'h00, beh(CODE_ZERO, CODE_OFF)});
    run = 1;
    step(40);
    chk("tmo", 16'h0000, {15'h0000, tmo});
    run = 0;
    step(40);
    chk("out", 16'h0001, {14'h0000, chan_out});
    step(60);
    chk("out0", 16'h0001, {15'h0000, chan_out[0]});
    chk("oe1", 16'h0000, {15'h0000, chan_oe[1]});
    wr(ADDR_CH1_BEH, {beh(CODE_REP, CODE_REP), beh(CODE_ALT, CODE_HOLD)}, 2'b11);
    run = 1;
    step(40);
    run = 0;
    step(40);
    a0 = chan_out[0];
    step(2);
    chk("alt", {15'h0000, ~a0}, {15'h0000, chan_out[0]});
    step(60);
    a0 = chan_out[0];
    ones = 0;
    repeat (8) begin
      step(2);
      ones += chan_out[1];
    end
    chk("hold", {15'h0000, a0}, {15'h0000, chan_out[0]});
    chk("rep", 16'($countones(last_data[15:8])), 16'(ones));
    end_of_test();
  end
endmodule : tb
`default_nettype wire
